// ===== logic/klm_pkg.sv
// klm_pkg: shared constants and types for the key learning mode controller
// assumes a 125 MHz pclk; long timing counts are also top-level parameters
package klm_pkg;

  // clock rate and derived cycles per millisecond
  localparam int unsigned CLK_HZ        = 125_000_000;
  localparam int unsigned CYC_PER_MS    = CLK_HZ / 1000;

  // times in milliseconds
  localparam int unsigned DEBOUNCE_MS   = 20;
  localparam int unsigned CLICK_GAP_MS  = 400;
  localparam int unsigned FAST_HALF_MS  = 500;   // one flash per second
  localparam int unsigned SLOW_HALF_MS  = 1500;  // three second period

  // derived counts in cycles
  localparam int unsigned DEBOUNCE_CYC  = DEBOUNCE_MS * CYC_PER_MS;
  localparam int unsigned CLICK_GAP_CYC = CLICK_GAP_MS * CYC_PER_MS;
  localparam int unsigned FAST_HALF_CYC = FAST_HALF_MS * CYC_PER_MS;
  localparam int unsigned SLOW_HALF_CYC = SLOW_HALF_MS * CYC_PER_MS;

  // block shape
  localparam int unsigned NUM_OUT       = 5;
  localparam int unsigned IDX_W         = 3;
  localparam int unsigned ADDR_W        = 16;

  // register byte offsets
  localparam logic [7:0] REG_CTRL       = 8'h00;
  localparam logic [7:0] REG_BIND       = 8'h04;
  localparam logic [7:0] REG_KEYCFG     = 8'h08;
  localparam logic [7:0] REG_OUTSET     = 8'h0C;
  localparam logic [7:0] REG_STATUS     = 8'h10;

  // control register fields
  localparam int unsigned CTRL_LEARN    = 0;
  localparam int unsigned CTRL_SYNC     = 1;
  localparam int unsigned CTRL_MESH     = 2;

  // bind and key config fields
  localparam int unsigned F_OUT_LSB     = 0;
  localparam int unsigned F_KEY_LSB     = 4;
  localparam int unsigned F_ADDR_LSB    = 16;

  // status register fields
  localparam int unsigned ST_MODE_LSB   = 0;
  localparam int unsigned ST_LEARNED    = 4;
  localparam int unsigned ST_OUT_LSB    = 12;
  localparam int unsigned ST_ADV        = 20;
  localparam int unsigned ST_LINK       = 21;

  // reset values
  localparam logic [15:0] KEY_ADDR_RST  = 16'hFFFF;  // broadcast target

  typedef enum logic [1:0] {
    KLM_NORMAL,
    KLM_LEARNER,
    KLM_SENDER
  } klm_mode_t;

  typedef enum logic [1:0] {
    KLM_CLK_IDLE,
    KLM_CLK_HELD,
    KLM_CLK_GAP,
    KLM_CLK_HELD2
  } klm_click_state_t;

endpackage : klm_pkg

// ===== logic/klm_blink.sv
// klm_blink: free running square wave for indicator flashing
// assumes one clock domain and a clock enable that freezes the count
`timescale 1ns/1ps
module klm_blink #(
  parameter int unsigned HALF_CYC = klm_pkg::FAST_HALF_CYC
) (
  input  wire logic pclk,
  input  wire logic presetn,
  input  wire logic ce,
  output logic      wave
);

  typedef struct packed {
    logic [31:0] cnt;
    logic        lvl;
  } klm_blink_t;

  klm_blink_t st;
  klm_blink_t next_st;

  // count half periods and flip the level
  always_comb begin
    next_st = st;
    if (st.cnt >= HALF_CYC - 1) begin
      next_st.cnt = '0;
      next_st.lvl = ~st.lvl;
    end else begin
      next_st.cnt = st.cnt + 32'h1;
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      st <= '0;
    end else if (ce) begin
      st <= next_st;
    end
  end

  assign wave = st.lvl;

endmodule : klm_blink

// ===== logic/klm_click.sv
// klm_click: debounce of the power/wake pin and single/double click split
// assumes the pin level is already synchronised; pressed means low
`timescale 1ns/1ps
module klm_click #(
  parameter int unsigned DEB_CYC = klm_pkg::DEBOUNCE_CYC,
  parameter int unsigned GAP_CYC = klm_pkg::CLICK_GAP_CYC
) (
  input  wire logic pclk,
  input  wire logic presetn,
  input  wire logic ce,
  input  wire logic pin_sync,
  output logic      pressed,
  output logic      press_pulse,
  output logic      single_pulse,
  output logic      double_pulse
);

  typedef struct packed {
    logic                      stable;   // debounced pressed level
    logic [31:0]               deb_cnt;
    logic [31:0]               gap_cnt;
    klm_pkg::klm_click_state_t cs;
    logic                      press;
    logic                      single;
    logic                      dbl;
  } klm_click_st_t;

  klm_click_st_t st;
  klm_click_st_t next_st;
  logic          raw_press;

  assign raw_press = ~pin_sync;

  // filter, then count clicks inside the gap window (see R20)
  always_comb begin
    next_st        = st;
    next_st.press  = 1'b0;
    next_st.single = 1'b0;
    next_st.dbl    = 1'b0;
    if (raw_press == st.stable) begin
      next_st.deb_cnt = '0;
    end else if (st.deb_cnt >= DEB_CYC - 1) begin
      next_st.deb_cnt = '0;
      next_st.stable  = raw_press;
      next_st.press   = raw_press;
    end else begin
      next_st.deb_cnt = st.deb_cnt + 32'h1;
    end
    case (st.cs)
      klm_pkg::KLM_CLK_IDLE: begin
        if (next_st.press) next_st.cs = klm_pkg::KLM_CLK_HELD;
      end
      klm_pkg::KLM_CLK_HELD: begin
        if (!st.stable) begin
          next_st.cs      = klm_pkg::KLM_CLK_GAP;
          next_st.gap_cnt = '0;
        end
      end
      klm_pkg::KLM_CLK_GAP: begin
        if (next_st.press) begin
          next_st.cs = klm_pkg::KLM_CLK_HELD2;
        end else if (st.gap_cnt >= GAP_CYC - 1) begin
          next_st.cs     = klm_pkg::KLM_CLK_IDLE;
          next_st.single = 1'b1;
        end else begin
          next_st.gap_cnt = st.gap_cnt + 32'h1;
        end
      end
      klm_pkg::KLM_CLK_HELD2: begin
        if (!st.stable) begin
          next_st.cs  = klm_pkg::KLM_CLK_IDLE;
          next_st.dbl = 1'b1;
        end
      end
      default: next_st.cs = klm_pkg::KLM_CLK_IDLE;
    endcase
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      st    <= '0;
      st.cs <= klm_pkg::KLM_CLK_IDLE;
    end else if (ce) begin
      st <= next_st;
    end
  end

  assign pressed      = st.stable;
  assign press_pulse  = st.press;
  assign single_pulse = st.single;
  assign double_pulse = st.dbl;

endmodule : klm_click

// ===== logic/klm_top.sv
// klm_top: mode control, output learning and indicator drive of a wireless node
// assumes an APB master on pclk, pins that are asynchronous to pclk, and
// radio-side status and receive strobes that already run on pclk
//
// The placing of the registers and register access over APB are this design's own decisions.
`timescale 1ns/1ps

// Function
// (R1) serial host binds local output to remote key and remote short address
// (R2) double click enters learner: link LED flashes slowly, advertising LED off
// (R3) while learning, unlearned output toggles each second, learned output stays on
// (R4) without local key press, output n binds to remote key n
// (R5) local key n selects output n; next received key binds to it
// (R6) single click enters sender: link LED off, advert slow, keys transmit
// (R7) double click leaves learner; bindings act only after leaving
// (R8) single click leaves sender; normal key functions resume afterwards
// (R9) in sender mode a pressed key drives its own output high
// (R10) normal: advertising LED flashes once per second; link LED on when connected
// (R11) reset is active low; an open reset pin reads as high
// (R12) wake pin press wakes device; connected writes need wake pin held low
// (R13) outside mesh, advertising LED flashes unconnected, stays on connected
// (R14) outside mesh, link output low unconnected, high connected
// (R15) in mesh, link output high only after joining the network
// (R16) outputs low after reset; settable by serial and remote keys when networked
// (R17) in mesh, a key press sends a set-level command to its target
// (R18) host enables learn switch and output sync before learning
// (R19) with learn switch on, key target writes are ignored
// (R20) wake pin is debounced; a fixed window splits single and double clicks
// (R21) slow flash period is clearly longer than the one second fast flash
module klm_top #(
  parameter int unsigned DEB_CYC   = klm_pkg::DEBOUNCE_CYC,
  parameter int unsigned GAP_CYC   = klm_pkg::CLICK_GAP_CYC,
  parameter int unsigned FAST_CYC  = klm_pkg::FAST_HALF_CYC,
  parameter int unsigned SLOW_CYC  = klm_pkg::SLOW_HALF_CYC
) (
  input  wire logic        pclk,
  input  wire logic        presetn,
  input  wire logic        ce,
  input  wire logic        psel,
  input  wire logic        penable,
  input  wire logic        pwrite,
  input  wire logic [7:0]  paddr,
  input  wire logic [31:0] pwdata,
  output logic             pready,
  output logic [31:0]      prdata,
  output logic             pslverr,
  input  wire logic        power_wake_pin,
  input  wire logic        key_input_a,
  input  wire logic        key_input_b,
  input  wire logic        key_input_c,
  input  wire logic        key_input_d,
  input  wire logic        key_input_e,
  input  wire logic        link_connected,
  input  wire logic        net_joined,
  input  wire logic        rx_valid,
  input  wire logic [2:0]  rx_key,
  input  wire logic [15:0] rx_addr,
  input  wire logic        rx_level,
  output logic             tx_valid,
  output logic [2:0]       tx_key,
  output logic [15:0]      tx_addr,
  output logic             tx_learn_code,
  output logic             wake_pulse,
  output logic             advert_led_pin,
  output logic             link_status_pin,
  output logic             driven_output_a,
  output logic             driven_output_b,
  output logic             driven_output_c,
  output logic             driven_output_d,
  output logic             driven_output_e
);

  localparam int unsigned N = klm_pkg::NUM_OUT;

  typedef struct packed {
    logic                      pwr_s1;
    logic                      pwr_s2;
    logic [N-1:0]              key_s1;
    logic [N-1:0]              key_s2;
    logic [N-1:0]              key_prev;
    klm_pkg::klm_mode_t        mode;
    logic                      learn_en;
    logic                      sync_en;
    logic                      mesh_mode;
    logic [N-1:0]              bind_valid;
    logic [N-1:0]              learned;
    logic [N-1:0][2:0]         bind_key;
    logic [N-1:0][15:0]        bind_addr;
    logic [N-1:0][15:0]        key_addr;
    logic                      free_act;
    logic [2:0]                free_sel;
    logic                      local_pressed;
    logic [N-1:0]              out_lvl;
    logic [N-1:0]              pin_out;
    logic                      adv;
    logic                      link;
    logic [31:0]               rdata;
    logic                      err;
    logic                      tx_v;
    logic [2:0]                tx_k;
    logic [15:0]               tx_a;
    logic                      tx_l;
  } klm_top_st_t;

  klm_top_st_t st;
  klm_top_st_t next_st;
  logic [N-1:0] key_raw;
  logic         click_single;
  logic         click_double;
  logic         click_press;
  logic         fast_wave;
  logic         slow_wave;
  logic         setup_ph;
  logic         access_ph;
  logic         wr_allowed;
  logic         networked;

  // key index 1..N is valid
  function automatic logic idx_ok(input logic [2:0] idx);
    idx_ok = (idx != 3'h0) && (idx <= 3'(N));
  endfunction : idx_ok

  // mapped register byte address
  function automatic logic addr_ok(input logic [7:0] a);
    addr_ok = (a == klm_pkg::REG_CTRL) || (a == klm_pkg::REG_BIND) || (a == klm_pkg::REG_KEYCFG) ||
              (a == klm_pkg::REG_OUTSET) || (a == klm_pkg::REG_STATUS);
  endfunction : addr_ok

  assign key_raw = {key_input_e, key_input_d, key_input_c, key_input_b, key_input_a};

  klm_click #(
    .DEB_CYC (DEB_CYC),
    .GAP_CYC (GAP_CYC)
  ) u_click (
    .pclk         (pclk),
    .presetn      (presetn),
    .ce           (ce),
    .pin_sync     (st.pwr_s2),
    .pressed      (),
    .press_pulse  (click_press),
    .single_pulse (click_single),
    .double_pulse (click_double)
  );

  klm_blink #(
    .HALF_CYC (FAST_CYC)
  ) u_fast (
    .pclk    (pclk),
    .presetn (presetn),
    .ce      (ce),
    .wave    (fast_wave)
  );

  klm_blink #(
    .HALF_CYC (SLOW_CYC)  // see R21
  ) u_slow (
    .pclk    (pclk),
    .presetn (presetn),
    .ce      (ce),
    .wave    (slow_wave)
  );

  // apb phases; zero wait states while enabled
  assign pready     = ce;
  assign setup_ph   = psel && !penable;
  assign access_ph  = psel && penable && ce;
  assign wr_allowed = !(link_connected && st.pwr_s2);  // see R12
  assign networked  = st.mesh_mode ? net_joined : link_connected;

  // next state of the whole block
  always_comb begin
    next_st          = st;
    next_st.tx_v     = 1'b0;
    // pin synchronisers; first stage feeds only the second
    next_st.pwr_s1   = power_wake_pin;
    next_st.pwr_s2   = st.pwr_s1;
    next_st.key_s1   = key_raw;
    next_st.key_s2   = st.key_s1;
    next_st.key_prev = st.key_s2;

    // mode switching from clicks
    case (st.mode)
      klm_pkg::KLM_NORMAL: begin
        if (click_double) begin
          next_st.mode          = klm_pkg::KLM_LEARNER;  // see R2
          next_st.learned       = '0;
          next_st.free_act      = 1'b0;
          next_st.local_pressed = 1'b0;
        end else if (click_single) begin
          next_st.mode = klm_pkg::KLM_SENDER;  // see R6
        end
      end
      klm_pkg::KLM_LEARNER: begin
        if (click_double) next_st.mode = klm_pkg::KLM_NORMAL;  // see R7
      end
      klm_pkg::KLM_SENDER: begin
        if (click_single) next_st.mode = klm_pkg::KLM_NORMAL;  // see R8
      end
      default: next_st.mode = klm_pkg::KLM_NORMAL;
    endcase

    // per key behaviour by mode
    for (int i = 0; i < N; i++) begin
      if (st.key_s2[i] && !st.key_prev[i]) begin
        if (st.mode == klm_pkg::KLM_LEARNER) begin
          next_st.free_act      = 1'b1;  // see R5
          next_st.free_sel      = 3'(i);
          next_st.local_pressed = 1'b1;
        end else begin
          next_st.tx_v = 1'b1;
          next_st.tx_k = 3'(i + 1);
          next_st.tx_l = (st.mode == klm_pkg::KLM_SENDER);  // see R6
          next_st.tx_a = st.key_addr[i];  // see R17
          if (st.mode == klm_pkg::KLM_NORMAL && st.sync_en) begin
            next_st.out_lvl[i] = ~st.out_lvl[i];
          end
        end
      end
    end

    // received key codes: learn while learning, control outputs in normal mode, ignored in sender mode
    if (rx_valid && idx_ok(rx_key)) begin
      if (st.mode == klm_pkg::KLM_LEARNER) begin
        if (st.free_act || next_st.free_act) begin
          next_st.bind_key[next_st.free_sel]   = rx_key;  // see R5
          next_st.bind_addr[next_st.free_sel]  = rx_addr;
          next_st.bind_valid[next_st.free_sel] = 1'b1;
          next_st.learned[next_st.free_sel]    = 1'b1;
          next_st.free_act                     = 1'b0;
        end else if (!st.local_pressed) begin
          next_st.bind_key[rx_key - 3'h1]   = rx_key;  // see R4
          next_st.bind_addr[rx_key - 3'h1]  = rx_addr;
          next_st.bind_valid[rx_key - 3'h1] = 1'b1;
          next_st.learned[rx_key - 3'h1]    = 1'b1;
        end
      end else if (st.mode == klm_pkg::KLM_NORMAL) begin
        // bindings only act once learner mode is left (see R7)
        for (int i = 0; i < N; i++) begin
          if (st.learn_en ? (st.bind_valid[i] && st.bind_key[i] == rx_key && st.bind_addr[i] == rx_addr)
                          : (rx_key == 3'(i + 1))) begin
            next_st.out_lvl[i] = rx_level;  // see R16
          end
        end
      end
    end

    // apb read data and error are captured in the setup cycle
    if (setup_ph) begin
      next_st.rdata = '0;
      next_st.err   = !addr_ok(paddr) || (pwrite && !wr_allowed);
      if (!pwrite) begin
        case (paddr)
          klm_pkg::REG_CTRL: begin
            next_st.rdata[klm_pkg::CTRL_LEARN] = st.learn_en;
            next_st.rdata[klm_pkg::CTRL_SYNC]  = st.sync_en;
            next_st.rdata[klm_pkg::CTRL_MESH]  = st.mesh_mode;
          end
          klm_pkg::REG_STATUS: begin
            next_st.rdata[klm_pkg::ST_MODE_LSB +: 2]    = st.mode;
            next_st.rdata[klm_pkg::ST_LEARNED +: N]     = st.learned;
            next_st.rdata[klm_pkg::ST_OUT_LSB +: N]     = st.pin_out;
            next_st.rdata[klm_pkg::ST_ADV]              = st.adv;
            next_st.rdata[klm_pkg::ST_LINK]             = st.link;
          end
          default: next_st.rdata = '0;
        endcase
      end
    end

    // apb writes take effect at the access edge
    if (access_ph && pwrite && wr_allowed) begin
      case (paddr)
        klm_pkg::REG_CTRL: begin
          next_st.learn_en  = pwdata[klm_pkg::CTRL_LEARN];  // see R18
          next_st.sync_en   = pwdata[klm_pkg::CTRL_SYNC];
          next_st.mesh_mode = pwdata[klm_pkg::CTRL_MESH];
        end
        klm_pkg::REG_BIND: begin
          if (idx_ok(pwdata[klm_pkg::F_OUT_LSB +: 3]) && idx_ok(pwdata[klm_pkg::F_KEY_LSB +: 3])) begin
            next_st.bind_key[pwdata[klm_pkg::F_OUT_LSB +: 3] - 3'h1]   = pwdata[klm_pkg::F_KEY_LSB +: 3];  // see R1
            next_st.bind_addr[pwdata[klm_pkg::F_OUT_LSB +: 3] - 3'h1]  = pwdata[klm_pkg::F_ADDR_LSB +: 16];
            next_st.bind_valid[pwdata[klm_pkg::F_OUT_LSB +: 3] - 3'h1] = 1'b1;
          end
        end
        klm_pkg::REG_KEYCFG: begin
          if (!st.learn_en && idx_ok(pwdata[klm_pkg::F_OUT_LSB +: 3])) begin  // see R19
            next_st.key_addr[pwdata[klm_pkg::F_OUT_LSB +: 3] - 3'h1] = pwdata[klm_pkg::F_ADDR_LSB +: 16];
          end
        end
        klm_pkg::REG_OUTSET: begin
          if (networked) next_st.out_lvl = pwdata[N-1:0];  // see R16
        end
        default: next_st.out_lvl = next_st.out_lvl;
      endcase
    end

    // registered pin drive per mode
    case (st.mode)
      klm_pkg::KLM_LEARNER: begin
        next_st.link = slow_wave;  // see R2
        next_st.adv  = 1'b0;
        for (int i = 0; i < N; i++) begin
          next_st.pin_out[i] = st.learned[i] ? 1'b1 : fast_wave;  // see R3
        end
      end
      klm_pkg::KLM_SENDER: begin
        next_st.link    = 1'b0;  // see R6
        next_st.adv     = slow_wave;
        next_st.pin_out = st.key_s2;  // see R9
      end
      default: begin
        if (st.mesh_mode) begin
          next_st.link = net_joined;  // see R15
          next_st.adv  = fast_wave;  // see R10
        end else begin
          next_st.link = link_connected;  // see R14
          next_st.adv  = link_connected ? 1'b1 : fast_wave;  // see R13
        end
        next_st.pin_out = st.out_lvl;  // see R8
      end
    endcase
  end

  // state register; reset holds outputs low (see R11)
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      st          <= '0;  // see R16
      st.pwr_s1   <= 1'b1;
      st.pwr_s2   <= 1'b1;
      st.mode     <= klm_pkg::KLM_NORMAL;
      st.key_addr <= {N{klm_pkg::KEY_ADDR_RST}};
    end else if (ce) begin
      st <= next_st;
    end
  end

  // output drive
  assign prdata          = st.rdata;
  assign pslverr         = st.err && access_ph;
  assign tx_valid        = st.tx_v;
  assign tx_key          = st.tx_k;
  assign tx_addr         = st.tx_a;
  assign tx_learn_code   = st.tx_l;
  assign wake_pulse      = click_press;  // see R12
  assign advert_led_pin  = st.adv;
  assign link_status_pin = st.link;
  assign driven_output_a = st.pin_out[0];
  assign driven_output_b = st.pin_out[1];
  assign driven_output_c = st.pin_out[2];
  assign driven_output_d = st.pin_out[3];
  assign driven_output_e = st.pin_out[4];

endmodule : klm_top

// ===== verif/klm_chk.sv
// klm_chk: port-level assertions for the key learning mode controller
// assumes a bind onto klm_top with every signal named as at its ports
`timescale 1ns/1ps
module klm_chk (
  input wire logic       pclk,
  input wire logic       presetn,
  input wire logic       ce,
  input wire logic       psel,
  input wire logic       penable,
  input wire logic [7:0] paddr,
  input wire logic       pready,
  input wire logic       pslverr,
  input wire logic       power_wake_pin,
  input wire logic       wake_pulse,
  input wire logic       tx_valid,
  input wire logic [2:0] tx_key,
  input wire logic       driven_output_a,
  input wire logic       driven_output_b,
  input wire logic       driven_output_c,
  input wire logic       driven_output_d,
  input wire logic       driven_output_e
);
  default clocking @(posedge pclk); endclocking
  default disable iff (!presetn);

  // bus answer and error flag placement
  bus_ready_a: assert property (pready == ce) else $error("pready not equal to ce");
  err_phase_a: assert property (pslverr |-> psel && penable) else $error("error flag outside access phase");
  err_unmapped_a: assert property (psel && penable && paddr > 8'h10 |-> pslverr) else $error("unmapped access not refused");
  // outputs come up low
  out_reset_a: assert property ($rose(presetn) |-> {driven_output_a, driven_output_b, driven_output_c,
    driven_output_d, driven_output_e} == 5'h00) else $error("outputs not low after reset");
  // key transmit strobe
  tx_pulse_a: assert property (tx_valid |=> !tx_valid) else $error("transmit strobe longer than one cycle");
  tx_key_a: assert property (tx_valid |-> tx_key inside {[3'h1:3'h5]}) else $error("transmit key out of range");
  // wake strobe follows a held-low pin
  wake_one_a: assert property (wake_pulse |=> !wake_pulse) else $error("wake strobe longer than one cycle");
  wake_cause_a: assert property (wake_pulse |-> !$past(power_wake_pin, 3)) else $error("wake without pin low");
endmodule : klm_chk

// ===== verif/klm_far.sv
// klm_far: user buttons and remote sender node facing the controller
// assumes tasks are entered right after a rising pclk edge
`timescale 1ns/1ps
module klm_far (
  input  wire logic  pclk,
  output logic       power_wake_pin,
  output logic [4:0] keys,
  output logic       rx_valid,
  output logic [2:0] rx_key,
  output logic [15:0] rx_addr,
  output logic       rx_level
);
  // idle levels: wake pin released high, keys up
  initial begin
    power_wake_pin = 1'b1;
    keys = 5'h00;
    rx_valid = 1'b0;
    rx_key = 3'h0;
    rx_addr = 16'h0000;
    rx_level = 1'b0;
  end

  // n clicks, each held well past the debounce time, gaps inside the window
  task automatic click(input int n);
    repeat (n) begin
      power_wake_pin <= 1'b0;
      repeat (10) @(posedge pclk);
      power_wake_pin <= 1'b1;
      repeat (10) @(posedge pclk);
    end
  endtask : click

  task automatic key(input int i, input logic lvl);
    keys[i] <= lvl;
    @(posedge pclk);
  endtask : key

  // one received key code, then the fields are scrambled so nothing stale reads valid
  task automatic send(input logic [2:0] k, input logic [15:0] a, input logic l);
    rx_valid <= 1'b1;
    rx_key <= k;
    rx_addr <= a;
    rx_level <= l;
    @(posedge pclk);
    rx_valid <= 1'b0;
    rx_key <= ~k;
    rx_addr <= ~a;
    rx_level <= ~l;
    @(posedge pclk);
  endtask : send
endmodule : klm_far

// ===== verif/testbench.sv
// testbench: register, click, learning and indicator sequences for klm_top
// assumes short timing parameters so each flash and click window is a few cycles
`timescale 1ns/1ps
module testbench;
  logic        pclk = 0, presetn = 0, ce = 1, psel = 0, penable = 0, pwrite = 0;
  logic [7:0]  paddr = 8'h00;
  logic [31:0] pwdata = 32'h0, prdata, rd;
  logic        pready, pslverr, err, link_connected = 0, net_joined = 0, adv, lnk;
  logic        pwake, rx_valid, rx_level, tx_valid, tx_learn_code;
  logic [4:0]  keys, outs;
  logic [2:0]  rx_key, tx_key;
  logic [15:0] rx_addr, tx_addr;
  int          bad_count = 0, checks = 0;

  always #4 pclk = ~pclk;

  klm_top #(.DEB_CYC(4), .GAP_CYC(40), .FAST_CYC(8), .SLOW_CYC(24)) uut (.pclk(pclk), .presetn(presetn), .ce(ce),
    .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .pready(pready),
    .prdata(prdata), .pslverr(pslverr), .power_wake_pin(pwake), .key_input_a(keys[0]), .key_input_b(keys[1]),
    .key_input_c(keys[2]), .key_input_d(keys[3]), .key_input_e(keys[4]), .link_connected(link_connected),
    .net_joined(net_joined), .rx_valid(rx_valid), .rx_key(rx_key), .rx_addr(rx_addr), .rx_level(rx_level),
    .tx_valid(tx_valid), .tx_key(tx_key), .tx_addr(tx_addr), .tx_learn_code(tx_learn_code), .wake_pulse(),
    .advert_led_pin(adv), .link_status_pin(lnk), .driven_output_a(outs[0]), .driven_output_b(outs[1]),
    .driven_output_c(outs[2]), .driven_output_d(outs[3]), .driven_output_e(outs[4]));

  klm_far far (.pclk(pclk), .power_wake_pin(pwake), .keys(keys), .rx_valid(rx_valid), .rx_key(rx_key),
    .rx_addr(rx_addr), .rx_level(rx_level));

  task automatic close_out();
    if (bad_count == 0 && checks > 0)
      $display("NO MISMATCHES");
    else
      $display("MISMATCHES SEEN");
    $finish;
  endtask : close_out

  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    checks++;
    if (seen !== exp) begin
      bad_count++;
      $display("unexpected at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask : check

  task automatic cyc(input int n);
    repeat (n) @(posedge pclk);
  endtask : cyc

  // one bus transfer, held until pready is seen high
  task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] d);
    int n;
    n = 0;
    psel <= 1'b1;
    pwrite <= wr;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    @(posedge pclk);
    while (pready !== 1'b1 && n < 50) begin
      @(posedge pclk);
      n++;
    end
    if (n == 50) bad_count++;
    rd = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    @(posedge pclk);
  endtask : apb

  // sees whether a flashing pin takes both levels within 30 cycles
  task automatic flashes(input bit use_adv);
    logic hi, lo, s;
    hi = 0;
    lo = 0;
    repeat (30) begin
      @(posedge pclk);
      s = use_adv ? adv : outs[0];
      if (s === 1'b1) hi = 1;
      if (s === 1'b0) lo = 1;
    end
    check({hi, lo}, 2'b11);
  endtask : flashes

  initial begin
    cyc(10);
    presetn <= 1'b1;
    @(posedge pclk);
    check(outs, 5'h00);
    apb(1, 8'h00, 32'h3);
    apb(0, 8'h00, 32'h0);
    check(rd, 32'h3);
    apb(0, 8'h14, 32'h0);
    check(rd | {err, 31'h0}, 32'h8000_0000);
    apb(1, 8'h00, 32'h0);
    // sender mode: key drives its own output and transmits
    far.click(1);
    cyc(60);
    apb(0, 8'h10, 32'h0);
    check(rd[1:0], 2'h2);
    check(lnk, 1'b0);
    far.key(2, 1'b1);
    cyc(8);
    check(outs, 5'h04);
    check({tx_learn_code, tx_key}, 4'hB);
    far.key(2, 1'b0);
    far.click(1);
    cyc(60);
    apb(0, 8'h10, 32'h0);
    check(rd[1:0], 2'h0);
    // learner mode: free learning of output b from remote key 5
    far.click(2);
    cyc(60);
    apb(0, 8'h10, 32'h0);
    check({rd[1:0], adv}, 3'h2);
    far.send(3'h3, 16'h0008, 1'b1);
    far.key(1, 1'b1);
    cyc(8);
    far.key(1, 1'b0);
    far.send(3'h5, 16'h0008, 1'b1);
    cyc(4);
    check(outs[2:1], 2'h3);
    flashes(0);
    far.click(2);
    cyc(60);
    apb(0, 8'h10, 32'h0);
    check(rd[1:0], 2'h0);
    apb(1, 8'h00, 32'h1);
    far.send(3'h5, 16'h0009, 1'b1);
    cyc(4);
    check(outs, 5'h00);
    far.send(3'h5, 16'h0008, 1'b1);
    cyc(4);
    check(outs, 5'h02);
    apb(1, 8'h04, 32'h0008_0013);
    far.send(3'h1, 16'h0008, 1'b1);
    cyc(4);
    check(outs, 5'h06);
    // key targets ignored while learning is switched on
    apb(1, 8'h08, 32'h1234_0001);
    far.key(0, 1'b1);
    cyc(8);
    check(tx_addr, 16'hFFFF);
    far.key(0, 1'b0);
    apb(1, 8'h00, 32'h0);
    apb(1, 8'h08, 32'h1234_0001);
    far.key(0, 1'b1);
    cyc(8);
    check(tx_addr, 16'h1234);
    far.key(0, 1'b0);
    // connection indicators outside and inside mesh operation
    link_connected <= 1'b1;
    cyc(4);
    check({adv, lnk}, 2'h3);
    apb(1, 8'h00, 32'h4);
    check(err, 1'b1);
    link_connected <= 1'b0;
    cyc(4);
    check(lnk, 1'b0);
    apb(1, 8'h00, 32'h4);
    net_joined <= 1'b1;
    cyc(4);
    check(lnk, 1'b1);
    flashes(1);
    net_joined <= 1'b0;
    cyc(4);
    check(lnk, 1'b0);
    // clock enable low freezes the flash prescaler
    ce <= 1'b0;
    cyc(2);
    rd = adv;
    cyc(20);
    check(adv, rd);
    ce <= 1'b1;
    close_out();
  end

  // watchdog against a hung handshake or wait
  initial begin
    cyc(20000);
    bad_count++;
    close_out();
  end
endmodule : testbench

bind klm_top klm_chk chk (.pclk(pclk), .presetn(presetn), .ce(ce), .psel(psel), .penable(penable), .paddr(paddr),
  .pready(pready), .pslverr(pslverr), .power_wake_pin(power_wake_pin), .wake_pulse(wake_pulse),
  .tx_valid(tx_valid), .tx_key(tx_key), .driven_output_a(driven_output_a), .driven_output_b(driven_output_b),
  .driven_output_c(driven_output_c), .driven_output_d(driven_output_d), .driven_output_e(driven_output_e));
